// ### core/bsas_top.sv
// Boot start address selection, config latch and flash programming registers
`timescale 1ns/1ns
module bsas_top
  import bsas_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic        boot_status,
  input  wire logic [7:0]  boot_vector,
  input  wire logic        isp_force_pin,
  input  wire logic [7:0]  power_up_config_byte,
  input  wire logic [63:0] sector_security_bytes,
  input  wire logic        sfr_wr,
  input  wire logic [1:0]  sfr_sel,
  input  wire logic [7:0]  sfr_wdata,
  input  wire logic        flash_done,
  output logic [15:0]      start_addr,
  output logic             start_valid,
  output logic             isp_mode,
  output logic [7:0]       config_q,
  output logic [63:0]      security_q,
  output logic [7:0]       sfr_rdata,
  output logic             flash_start,
  output logic [7:0]       flash_cmd,
  output logic [7:0]       flash_wdata,
  output logic [15:0]      flash_addr,
  output logic             flash_busy
);

  ////////////////////////////////////////////////////////////////////////
  // Pin synchroniser; only the second stage is read
  logic force_s1_q;
  logic force_s2_q;
  bsas_state_t state_q;

  // No reset: the pin must reach stage two while reset still holds
  always_ff @(posedge clk)
  begin
    force_s1_q <= isp_force_pin;
    force_s2_q <= force_s1_q;
  end

  ////////////////////////////////////////////////////////////////////////
  // Sampling sequence: waits one cycle so the synchroniser settles
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_q <= BSAS_ST_RESET;
    else
    begin
      case (state_q)
        BSAS_ST_RESET:  state_q <= BSAS_ST_SAMPLE;
        BSAS_ST_SAMPLE: state_q <= BSAS_ST_READY;
        BSAS_ST_READY:  state_q <= BSAS_ST_READY;
        default:        state_q <= BSAS_ST_RESET;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Start address is frozen once ready; fetch must wait for start_valid
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      start_addr  <= BSAS_USER_START;
      start_valid <= 1'b0;
      isp_mode    <= 1'b0;
    end
    else if (state_q == BSAS_ST_SAMPLE)
    begin
      start_valid <= 1'b1;
      isp_mode    <= force_s2_q;
      if (boot_status || force_s2_q)
        start_addr <= {boot_vector, BSAS_LOW_BYTE};
      else
        start_addr <= BSAS_USER_START;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Config and security latched once; no write path exists afterwards
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      config_q   <= BSAS_CFG_RESET;
      security_q <= {BSAS_SECTORS{BSAS_SEC_RESET}};
    end
    else if (state_q == BSAS_ST_SAMPLE)
    begin
      config_q   <= power_up_config_byte;
      security_q <= sector_security_bytes;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Four programming registers: control/status, data, address low/high
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      flash_cmd   <= 8'h00;
      flash_wdata <= 8'h00;
      flash_addr  <= 16'h0000;
      flash_busy  <= 1'b0;
      flash_start <= 1'b0;
    end
    else
    begin
      flash_start <= 1'b0;
      if (flash_done)
        flash_busy <= 1'b0;
      // Writes while busy are dropped to keep the operation coherent
      if (sfr_wr && !flash_busy)
      begin
        case (sfr_sel)
          BSAS_SFR_CTRL:
          begin
            flash_cmd   <= sfr_wdata;
            flash_start <= 1'b1;
            flash_busy  <= 1'b1;
          end
          BSAS_SFR_DATA:    flash_wdata      <= sfr_wdata;
          BSAS_SFR_ADDR_LO: flash_addr[7:0]  <= sfr_wdata;
          BSAS_SFR_ADDR_HI: flash_addr[15:8] <= sfr_wdata;
          default:          flash_cmd        <= flash_cmd;
        endcase
      end
    end
  end

  always_comb
  begin
    case (sfr_sel)
      BSAS_SFR_CTRL:    sfr_rdata = {7'h00, flash_busy};
      BSAS_SFR_DATA:    sfr_rdata = flash_wdata;
      BSAS_SFR_ADDR_LO: sfr_rdata = flash_addr[7:0];
      BSAS_SFR_ADDR_HI: sfr_rdata = flash_addr[15:8];
      default:          sfr_rdata = 8'h00;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks
  AST_USER_START: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSAS_ST_SAMPLE && !boot_status && !force_s2_q)
      |=> start_addr == BSAS_USER_START)
    else $error("user start not 0000H");
  AST_VECTOR_START: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSAS_ST_SAMPLE && boot_status)
      |=> start_addr == {$past(boot_vector), BSAS_LOW_BYTE})
    else $error("vector start wrong");
  AST_FORCE_START: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSAS_ST_SAMPLE && force_s2_q)
      |=> start_addr[7:0] == BSAS_LOW_BYTE && isp_mode)
    else $error("forced start wrong");
  AST_VALID_TIME: assert property (@(posedge clk) disable iff (!rstn)
    $rose(start_valid) |-> $past(state_q) == BSAS_ST_SAMPLE)
    else $error("valid early");
  AST_ADDR_STABLE: assert property (@(posedge clk) disable iff (!rstn)
    start_valid && $past(start_valid) |-> $stable(start_addr))
    else $error("start address moved");
  AST_CFG_FROZEN: assert property (@(posedge clk) disable iff (!rstn)
    start_valid && $past(start_valid) |-> $stable(config_q))
    else $error("config changed");
  AST_SEC_FROZEN: assert property (@(posedge clk) disable iff (!rstn)
    start_valid && $past(start_valid) |-> $stable(security_q))
    else $error("security changed");
  AST_CMD_START: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_wr && !flash_busy && sfr_sel == BSAS_SFR_CTRL)
      |=> flash_start && flash_busy && flash_cmd == $past(sfr_wdata))
    else $error("command not started");
  AST_BUSY_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    flash_busy && sfr_wr && sfr_sel == BSAS_SFR_DATA
      |=> $stable(flash_wdata))
    else $error("write while busy taken");
  AST_VALID_HOLD: assert property (@(posedge clk) disable iff (!rstn)
    start_valid |=> start_valid)
    else $error("start valid dropped");
  AST_READY_ORDER: assert property (@(posedge clk) disable iff (!rstn)
    !start_valid |-> state_q != BSAS_ST_READY)
    else $error("ready state without valid start");
  AST_SHIP_VECTOR: assert property (@(posedge clk) disable iff (!rstn)
    (state_q == BSAS_ST_SAMPLE && boot_status
      && boot_vector == BSAS_VECTOR_RESET)
      |=> start_addr == {BSAS_VECTOR_RESET, BSAS_LOW_BYTE})
    else $error("factory loader entry wrong");
  AST_LATCH: assert property (@(posedge clk) disable iff (!rstn)
    state_q == BSAS_ST_SAMPLE
      |=> config_q == $past(power_up_config_byte)
        && security_q == $past(sector_security_bytes))
    else $error("config or security not latched");
  AST_FORCE_OFF: assert property (@(posedge clk) disable iff (!rstn)
    state_q == BSAS_ST_SAMPLE && !force_s2_q |=> !isp_mode)
    else $error("isp mode without force");
  AST_DONE_CLEARS: assert property (@(posedge clk) disable iff (!rstn)
    flash_done && !(sfr_wr && !flash_busy && sfr_sel == BSAS_SFR_CTRL)
      |=> !flash_busy)
    else $error("busy not cleared by done");
  AST_START_PULSE: assert property (@(posedge clk) disable iff (!rstn)
    flash_start |=> !flash_start)
    else $error("start pulse too long");
  AST_START_BUSY: assert property (@(posedge clk) disable iff (!rstn)
    flash_start |-> flash_busy)
    else $error("start without busy");
  AST_ADDR_LO_WR: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_wr && !flash_busy && sfr_sel == BSAS_SFR_ADDR_LO)
      |=> flash_addr[7:0] == $past(sfr_wdata))
    else $error("address low not written");
  AST_ADDR_HI_WR: assert property (@(posedge clk) disable iff (!rstn)
    (sfr_wr && !flash_busy && sfr_sel == BSAS_SFR_ADDR_HI)
      |=> flash_addr[15:8] == $past(sfr_wdata))
    else $error("address high not written");

  COV_USER: cover property (@(posedge clk) disable iff (!rstn)
    $rose(start_valid) && !isp_mode && start_addr == BSAS_USER_START);
  COV_FORCE: cover property (@(posedge clk) disable iff (!rstn)
    $rose(start_valid) && isp_mode);
  COV_FLASH: cover property (@(posedge clk) disable iff (!rstn)
    flash_start ##[1:20] flash_done);
  COV_VECTOR: cover property (@(posedge clk) disable iff (!rstn)
    $rose(start_valid) && !isp_mode && start_addr != BSAS_USER_START);
  COV_BUSY_DROP: cover property (@(posedge clk) disable iff (!rstn)
    flash_busy && sfr_wr);

endmodule : bsas_top

// ### core/bsas_pkg.sv
// Package: constants and types for the boot start address selector
package bsas_pkg;
  localparam logic [15:0] BSAS_USER_START     = 16'h0000;
  localparam logic [7:0]  BSAS_LOW_BYTE       = 8'h00;
  localparam logic [7:0]  BSAS_VECTOR_RESET   = 8'h1F;
  localparam logic [15:0] BSAS_ROM_ENTRY      = 16'hFF03;
  localparam int          BSAS_SECTORS        = 8;
  localparam int          BSAS_SFR_COUNT      = 4;
  localparam logic [1:0]  BSAS_SFR_CTRL       = 2'h0;
  localparam logic [1:0]  BSAS_SFR_DATA       = 2'h1;
  localparam logic [1:0]  BSAS_SFR_ADDR_LO    = 2'h2;
  localparam logic [1:0]  BSAS_SFR_ADDR_HI    = 2'h3;
  localparam logic [7:0]  BSAS_CFG_RESET      = 8'h00;
  localparam logic [7:0]  BSAS_SEC_RESET      = 8'h00;
  localparam int          BSAS_SYNC_STAGES    = 2;

  typedef enum logic [1:0]
  {
    BSAS_ST_RESET  = 2'b00,
    BSAS_ST_SAMPLE = 2'b01,
    BSAS_ST_READY  = 2'b10
  } bsas_state_t;
endpackage : bsas_pkg

// ### testbench/bsas_fetch_model.sv
// Firmware side model that answers flash starts with a done pulse
`timescale 1ns/1ns
module bsas_fetch_model
(
  input  wire logic       clk,
  input  wire logic       flash_start,
  input  wire logic [3:0] lat,
  output logic            flash_done
);
  int cnt = 0;
  initial flash_done = 1'b0;
  // Latency is variable so the busy window is not a fixed shape
  always @(posedge clk)
  begin
    flash_done <= 1'b0;
    if (flash_start)
      cnt <= lat;
    else if (cnt > 0)
    begin
      cnt <= cnt - 1;
      flash_done <= (cnt == 1);
    end
  end
endmodule : bsas_fetch_model

// ### testbench/bsas_top_tb.sv
// Self-checking bench for the boot start address selector
`timescale 1ns/1ns
module bsas_top_tb;
  import bsas_pkg::*;
  logic        clk = 0, rstn = 0, bstat = 0, force_p = 0, wr = 0, done;
  logic [7:0]  vec = 0, cfg = 0, wd = 0, cq, rd, fc, fw;
  logic [63:0] sec = 0, sq;
  logic [1:0]  sel = 0;
  logic [15:0] sa, fa;
  logic        sv, ism, fs, fb;
  logic [3:0]  lat = 4'h4;
  logic [31:0] rs = 32'h2270;
  int          num_errors = 0, total_checks = 0, exp_a, k;
  localparam logic [15:0] loader_sector  = 16'h1C00;
  localparam logic [7:0]  page_erase_cmd = 8'h01; // Code is arbitrary
  always #25 clk = ~clk;
  bsas_top dut (.clk(clk), .rstn(rstn), .boot_status(bstat),
    .boot_vector(vec), .isp_force_pin(force_p),
    .power_up_config_byte(cfg), .sector_security_bytes(sec),
    .sfr_wr(wr), .sfr_sel(sel), .sfr_wdata(wd), .flash_done(done),
    .start_addr(sa), .start_valid(sv), .isp_mode(ism), .config_q(cq),
    .security_q(sq), .sfr_rdata(rd), .flash_start(fs), .flash_cmd(fc),
    .flash_wdata(fw), .flash_addr(fa), .flash_busy(fb));
  bsas_fetch_model fw_model (.clk(clk), .flash_start(fs), .lat(lat),
    .flash_done(done));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] nxt(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction : nxt
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test
  // Waits a falling edge first, so wr never moves twice in one step
  task automatic sfr(input logic [1:0] s, input logic [7:0] d);
    @(negedge clk);
    sel = s;
    wd = d;
    wr = 1'b1;
    @(negedge clk);
    wr = 1'b0;
  endtask : sfr
  task automatic wait_idle;
    k = 0;
    while (fb !== 1'b0 && k < 40)
    begin
      @(negedge clk);
      k++;
    end
    if (fb !== 1'b0)
      num_errors++;
  endtask : wait_idle
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    for (int i = 0; i < 5; i++)
    begin
      rs = nxt(rs);
      @(negedge clk);
      rstn = 1'b0;
      bstat = i[0] | (i == 4);
      force_p = i[1];
      vec = (i == 4) ? BSAS_VECTOR_RESET : rs[7:0];
      cfg = rs[15:8];
      sec = {rs, ~rs};
      repeat (8) @(negedge clk);
      rstn = 1'b1;
      @(negedge clk);
      chk(sv, 1'b0);
      @(negedge clk);
      exp_a = (bstat | force_p) ? vec * 256 : 0;
      chk(sv, 1'b1);
      chk(sa, exp_a[15:0]);
      chk(ism, force_p);
      chk(cq, cfg);
      chk(sq, sec);
      // Late changes must not disturb what was latched
      {bstat, force_p, vec, cfg, sec} = ~{bstat, force_p, vec, cfg, sec};
      repeat (2) @(negedge clk);
      chk({sa, cq}, {exp_a[15:0], ~cfg});
      chk(sq, ~sec);
    end
    rs = nxt(rs);
    lat = 4'h4 + {2'h0, rs[1:0]};
    sfr(BSAS_SFR_ADDR_HI, rs[15:8]);
    sfr(BSAS_SFR_ADDR_LO, rs[7:0]);
    sfr(BSAS_SFR_DATA, rs[23:16]);
    chk({fw, fa}, rs[23:0]);
    chk(rd, rs[23:16]);
    sfr(BSAS_SFR_CTRL, rs[31:24]);
    chk({fs, fb, fc}, {2'b11, rs[31:24]});
    sfr(BSAS_SFR_DATA, ~rs[23:16]);
    chk({fs, fw}, {1'b0, rs[23:16]});
    sel = BSAS_SFR_CTRL;
    #1 chk(rd, 8'h01);
    wait_idle();
    chk(rd, 8'h00);
    // Keep the loader: erase only the lower eight pages of its sector
    for (int p = 0; p < 8; p++)
    begin
      exp_a = loader_sector + p * 64;
      sfr(BSAS_SFR_ADDR_LO, exp_a[7:0]);
      sfr(BSAS_SFR_ADDR_HI, exp_a[15:8]);
      sfr(BSAS_SFR_CTRL, page_erase_cmd);
      chk({fs, fb, fc, fa}, {2'b11, page_erase_cmd, exp_a[15:0]});
      wait_idle();
    end
    // Programmer clears the boot status, so the next reset runs user code
    @(negedge clk);
    rstn = 1'b0;
    bstat = 1'b0;
    force_p = 1'b0;
    repeat (8) @(negedge clk);
    rstn = 1'b1;
    repeat (2) @(negedge clk);
    chk({sv, ism, sa}, {2'b10, BSAS_USER_START});
    end_of_test;
  end
endmodule : bsas_top_tb
